// [design/iscp_pkg.sv]
// constants for the serial configuration port
package iscp_pkg;
  // ----------------------------------------
  // addressing
  // ----------------------------------------
  localparam logic [6:0] ISCP_TARGET_ADDR = 7'h69;
  localparam int ISCP_REG_COUNT = 32;
  localparam logic [7:0] ISCP_IDX_CLOCK_OUT_CONFIG = 8'h01;
  localparam logic [7:0] ISCP_IDX_SYNTH_DIVIDER_CONFIG = 8'h08;
  localparam logic [7:0] ISCP_IDX_CARRIER_WORD_A_WORD_HIGH = 8'h0b;
  localparam logic [7:0] ISCP_IDX_CARRIER_WORD_A_WORD_MID = 8'h0c;
  localparam logic [7:0] ISCP_IDX_CARRIER_WORD_A_WORD_LOW = 8'h0d;
  localparam logic [7:0] ISCP_IDX_TX_DATA = 8'h13;
  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int ISCP_CLK_DELAY_MSB = 7;
  localparam int ISCP_CLK_DELAY_LSB = 6;
  localparam logic [7:0] ISCP_CLOCK_OUT_CONFIG_RST = 8'h80;
  localparam logic [7:0] ISCP_SYNTH_DIVIDER_CONFIG_RST = 8'h00;
  localparam int ISCP_FRAC_BIT = 7;
  localparam int ISCP_DIV_MSB = 1;
  localparam int ISCP_DIV_LSB = 0;
  localparam logic [1:0] ISCP_DIV_NORMAL = 2'h0;
  localparam logic [1:0] ISCP_DIV_LPN_860 = 2'h1;
  localparam logic [1:0] ISCP_DIV_LPN_425 = 2'h2;
  localparam logic [1:0] ISCP_DIV_LPN_286 = 2'h3;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int ISCP_CLK_HZ = 100_000_000;
  localparam int ISCP_BUFFERED_CLOCK_OUTPUT_HZ = 800_000;
  localparam int ISCP_BUFFERED_CLOCK_OUTPUT_HALF = ISCP_CLK_HZ / (2 * ISCP_BUFFERED_CLOCK_OUTPUT_HZ);
  localparam int ISCP_SCL_MAX_HZ = 1_000_000;
endpackage

// [design/iscp_sync.sv]
// two-flop synchroniser for an input from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module iscp_sync
  import iscp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // level in and out
  input wire logic din,
  output logic dout
);
  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
    end
    else
    begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;
endmodule
`default_nettype wire

// [design/iscp_buffered_clock_output.sv]
// 800 khz buffered clock generator for preset mode
`timescale 1ns/10ps
`default_nettype none
module iscp_buffered_clock_output
  import iscp_pkg::*;
#(
  parameter int HALF = ISCP_BUFFERED_CLOCK_OUTPUT_HALF
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic run,
  // output
  output logic clk_out
);
  logic [7:0] cnt_ff;
  logic clk_out_ff;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_ff <= 8'h00;
      clk_out_ff <= 1'b0;
    end
    else if (!run)
    begin
      cnt_ff <= 8'h00;
      clk_out_ff <= 1'b0;
    end
    else if (cnt_ff == 8'(HALF - 1))
    begin
      cnt_ff <= 8'h00;
      clk_out_ff <= ~clk_out_ff;
    end
    else
    begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  assign clk_out = clk_out_ff;
endmodule
`default_nettype wire

// [design/iscp_top.sv]
// serial target port with synthesizer configuration registers
// Operation
// - port active only with both selects grounded
// - controller clocks transfers up to 1MHz
// - nine clocks per byte, eight data plus ack
// - data change while clock high is control
// - detect start and stop conditions
// - ack holds data low through ninth pulse
// - nack leaves data released in ninth pulse
// - fixed address, d2 write, d3 read
// - watch start plus address, ack on match
// - write sends index then data, each acked
// - index increments, write open until stop
// - read after index write and repeated start
// - controller ack continues read, nack ends
// - divider codes for normal and low noise
// - fractional bit clear selects integer-n
// - 24-bit fractional divider ratio 11 to 72
// - preset mode drives 800kHz clock output
// - delay field defaults 2, preset only
// - idle bus lines both released high
// - no index advance at transmit data register on writes; reads still advance past it
// - refuse programming in standby, wake on address
`timescale 1ns/10ps
`default_nettype none
module iscp_top
  import iscp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration select pins
  input wire logic config_select_a,
  input wire logic config_select_b,
  // serial clock pin, also the preset clock output
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  // serial data pin
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // power state from the device core
  input wire logic low_power,
  output logic wake_pulse,
  // synthesizer configuration
  output logic [23:0] carrier_word_a,
  output logic [1:0] osc_divider_select,
  output logic fractional_synth_enable,
  output logic [1:0] clock_output_delay,
  // transmit data register strobe
  output logic tx_data_valid,
  output logic [7:0] tx_data
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic scl_s;
  logic sda_s;
  logic sel_a_s;
  logic sel_b_s;

  // 100 MHz sampling leaves margin for a 1 MHz bus clock
  iscp_sync u_sync_scl (.clk(clk), .rst(rst), .din(scl_in), .dout(scl_s));
  iscp_sync u_sync_sda (.clk(clk), .rst(rst), .din(sda_in), .dout(sda_s));
  iscp_sync u_sync_sa (.clk(clk), .rst(rst), .din(config_select_a),
    .dout(sel_a_s));
  iscp_sync u_sync_sb (.clk(clk), .rst(rst), .din(config_select_b),
    .dout(sel_b_s));

  logic prog_mode;
  assign prog_mode = !sel_a_s && !sel_b_s;

  logic scl_d_ff;
  logic sda_d_ff;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end
    else
    begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise = prog_mode && scl_s && !scl_d_ff;
  assign scl_fall = prog_mode && !scl_s && scl_d_ff;
  // sda moving while scl high is control, never data
  assign start_det = prog_mode && scl_s && scl_d_ff && sda_d_ff && !sda_s;
  assign stop_det = prog_mode && scl_s && scl_d_ff && !sda_d_ff && sda_s;

  // ----------------------------------------
  // protocol state machine
  // ----------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_RECV = 6'b000010,
    ST_ACK = 6'b000100,
    ST_SEND = 6'b001000,
    ST_RACK = 6'b010000,
    ST_WAIT = 6'b100000
  } iscp_state_t;

  typedef enum logic [2:0] {
    PH_ADDR = 3'b001,
    PH_INDEX = 3'b010,
    PH_DATA = 3'b100
  } iscp_phase_t;

  iscp_state_t state_ff;
  iscp_phase_t phase_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] index_ff;
  logic read_ff;
  logic ack_drive_ff;
  logic send_drive_ff;
  logic [7:0] regs_ff [ISCP_REG_COUNT];

  logic [7:0] rx_byte;
  logic addr_match;
  logic index_ok;
  logic [7:0] rd_byte;
  // the shifter already holds all eight bits by the eighth fall
  assign rx_byte = shift_ff;
  assign addr_match = rx_byte[7:1] == ISCP_TARGET_ADDR;
  assign index_ok = index_ff < 8'(ISCP_REG_COUNT);
  assign rd_byte = index_ok ? regs_ff[index_ff[4:0]] : 8'h00;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= ST_IDLE;
    end
    else if (!prog_mode || stop_det)
    begin
      state_ff <= ST_IDLE;
    end
    else if (start_det)
    begin
      state_ff <= ST_RECV;
    end
    else
    begin
      unique case (state_ff)
        ST_IDLE: state_ff <= ST_IDLE;
        ST_RECV:
        begin
          if (scl_fall && bit_cnt_ff == 4'd8)
          begin
            // foreign address is ignored until the next start
            if (phase_ff == PH_ADDR && !addr_match)
              state_ff <= ST_WAIT;
            else if (phase_ff != PH_ADDR && low_power)
              state_ff <= ST_WAIT;
            else
              state_ff <= ST_ACK;
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
            state_ff <= read_ff ? ST_SEND : ST_RECV;
        end
        ST_SEND:
        begin
          // eighth data fall: release sda before the ack clock rises
          if (scl_fall && bit_cnt_ff == 4'd7)
            state_ff <= ST_RACK;
        end
        ST_RACK:
        begin
          // a nack stops the data; the port then waits for a stop or a new start
          if (scl_rise)
            state_ff <= sda_s ? ST_WAIT : ST_RACK;
          else if (scl_fall)
            state_ff <= ST_SEND;
        end
        ST_WAIT: state_ff <= ST_WAIT;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // address/index/data phase tracking
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      phase_ff <= PH_ADDR;
      read_ff <= 1'b0;
    end
    else if (start_det || !prog_mode)
    begin
      phase_ff <= PH_ADDR;
      read_ff <= 1'b0;
    end
    else if (state_ff == ST_ACK && scl_fall)
    begin
      if (phase_ff == PH_ADDR)
        phase_ff <= read_ff ? PH_DATA : PH_INDEX;
      else
        phase_ff <= PH_DATA;
    end
    else if (state_ff == ST_RECV && scl_fall && bit_cnt_ff == 4'd8
             && phase_ff == PH_ADDR)
    begin
      read_ff <= rx_byte[0];
    end
  end

  // bit counter and shifter; sample on rise, shift out on fall
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bit_cnt_ff <= 4'd0;
      shift_ff <= 8'h00;
    end
    else if (start_det)
    begin
      bit_cnt_ff <= 4'd0;
    end
    else if (state_ff == ST_RECV && scl_rise)
    begin
      shift_ff <= {shift_ff[6:0], sda_s};
      bit_cnt_ff <= bit_cnt_ff + 4'd1;
    end
    else if (state_ff == ST_RECV && scl_fall && bit_cnt_ff == 4'd8)
    begin
      bit_cnt_ff <= 4'd0;
    end
    else if ((state_ff == ST_ACK || state_ff == ST_RACK) && scl_fall)
    begin
      // load next byte msb first for a read
      shift_ff <= rd_byte;
      bit_cnt_ff <= 4'd0;
    end
    else if (state_ff == ST_SEND && scl_fall)
    begin
      shift_ff <= {shift_ff[6:0], 1'b0};
      bit_cnt_ff <= bit_cnt_ff + 4'd1;
    end
  end

  // ----------------------------------------
  // register index and write path
  // ----------------------------------------
  logic wr_hit;
  assign wr_hit = state_ff == ST_RECV && scl_fall && bit_cnt_ff == 4'd8
                  && phase_ff == PH_DATA && !low_power;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      index_ff <= 8'h00;
    end
    else if (state_ff == ST_RECV && scl_fall && bit_cnt_ff == 4'd8
             && phase_ff == PH_INDEX && !low_power)
    begin
      index_ff <= rx_byte;
    end
    else if (wr_hit && index_ff != ISCP_IDX_TX_DATA)
    begin
      index_ff <= index_ff + 8'h01;
    end
    else if (state_ff == ST_RACK && scl_rise && !sda_s)
    begin
      index_ff <= index_ff + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < ISCP_REG_COUNT; i++)
        regs_ff[i] <= 8'h00;
      regs_ff[ISCP_IDX_CLOCK_OUT_CONFIG[4:0]] <= ISCP_CLOCK_OUT_CONFIG_RST;
      regs_ff[ISCP_IDX_SYNTH_DIVIDER_CONFIG[4:0]] <=
        ISCP_SYNTH_DIVIDER_CONFIG_RST;
    end
    else if (wr_hit && index_ok)
    begin
      regs_ff[index_ff[4:0]] <= rx_byte;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_data_valid <= 1'b0;
      tx_data <= 8'h00;
    end
    else
    begin
      tx_data_valid <= wr_hit && index_ff == ISCP_IDX_TX_DATA;
      if (wr_hit && index_ff == ISCP_IDX_TX_DATA)
        tx_data <= rx_byte;
    end
  end

  // address recognition wakes the core
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wake_pulse <= 1'b0;
    else
      wake_pulse <= state_ff == ST_RECV && scl_fall && bit_cnt_ff == 4'd8
                    && phase_ff == PH_ADDR && addr_match;
  end

  // ----------------------------------------
  // synthesizer fields
  // ----------------------------------------
  // the word is taken as written; odd values are left to software
  assign carrier_word_a = {regs_ff[ISCP_IDX_CARRIER_WORD_A_WORD_HIGH[4:0]],
                           regs_ff[ISCP_IDX_CARRIER_WORD_A_WORD_MID[4:0]],
                           regs_ff[ISCP_IDX_CARRIER_WORD_A_WORD_LOW[4:0]]};
  assign osc_divider_select = regs_ff[ISCP_IDX_SYNTH_DIVIDER_CONFIG[4:0]]
                              [ISCP_DIV_MSB:ISCP_DIV_LSB];
  assign fractional_synth_enable =
    regs_ff[ISCP_IDX_SYNTH_DIVIDER_CONFIG[4:0]][ISCP_FRAC_BIT];
  // delay only reaches the core in preset mode
  assign clock_output_delay = prog_mode ? 2'h0 :
    regs_ff[ISCP_IDX_CLOCK_OUT_CONFIG[4:0]]
    [ISCP_CLK_DELAY_MSB:ISCP_CLK_DELAY_LSB];

  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  logic clk_out;
  iscp_buffered_clock_output u_buffered_clock_output (.clk(clk), .rst(rst), .run(!prog_mode),
    .clk_out(clk_out));
  assign scl_out = clk_out;
  assign scl_oe = !prog_mode;

  // drive changes only after scl fell, so data is stable while high
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ack_drive_ff <= 1'b0;
      send_drive_ff <= 1'b0;
    end
    else
    begin
      ack_drive_ff <= state_ff == ST_ACK && prog_mode && !stop_det;
      send_drive_ff <= state_ff == ST_SEND && !shift_ff[7]
                       && prog_mode && !stop_det;
    end
  end

  assign sda_out = 1'b0;
  // released in idle, wait and nack slots
  assign sda_oe = ack_drive_ff || send_drive_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  preset_clk_a: assert property (@(posedge clk) disable iff (rst)
    !prog_mode |-> scl_oe && !sda_oe)
    else $error("pins misdriven in preset mode");
  idle_release_a: assert property (@(posedge clk) disable iff (rst)
    state_ff == ST_IDLE |=> !sda_oe)
    else $error("sda driven while idle");
  ack_hold_a: assert property (@(posedge clk) disable iff (rst)
    state_ff == ST_ACK && $past(state_ff == ST_ACK) && prog_mode
    && !stop_det |=> sda_oe)
    else $error("ack not held");
  foreign_addr_a: assert property (@(posedge clk) disable iff (rst)
    state_ff == ST_RECV && scl_fall && bit_cnt_ff == 4'd8
    && phase_ff == PH_ADDR && !addr_match && !start_det && !stop_det
    |=> state_ff == ST_WAIT)
    else $error("foreign address accepted");
  stop_idle_a: assert property (@(posedge clk) disable iff (rst)
    stop_det |=> state_ff == ST_IDLE)
    else $error("stop not seen");
  start_recv_a: assert property (@(posedge clk) disable iff (rst)
    start_det && !stop_det |=> state_ff == ST_RECV && bit_cnt_ff == 4'd0)
    else $error("start not seen");
  tx_hold_a: assert property (@(posedge clk) disable iff (rst)
    wr_hit && index_ff == ISCP_IDX_TX_DATA |=> index_ff == ISCP_IDX_TX_DATA)
    else $error("index moved past tx data");
  incr_a: assert property (@(posedge clk) disable iff (rst)
    wr_hit && index_ff != ISCP_IDX_TX_DATA
    |=> index_ff == $past(index_ff) + 8'h01)
    else $error("index did not advance");
  nine_clk_a: assert property (@(posedge clk) disable iff (rst)
    bit_cnt_ff <= 4'd8)
    else $error("bit count beyond nine clocks");
  delay_prog_a: assert property (@(posedge clk) disable iff (rst)
    prog_mode |-> clock_output_delay == 2'h0)
    else $error("delay leaks into programming mode");
  cov_write_c: cover property (@(posedge clk) disable iff (rst) wr_hit);
  cov_read_c: cover property (@(posedge clk) disable iff (rst)
    state_ff == ST_RACK && scl_rise && !sda_s);
  cov_nack_c: cover property (@(posedge clk) disable iff (rst)
    state_ff == ST_RACK && scl_rise && sda_s);
  cov_foreign_c: cover property (@(posedge clk) disable iff (rst)
    state_ff == ST_WAIT);
endmodule
`default_nettype wire

// [verification/iscp_ctrl_model.sv]
// serial bus controller model driving the open-drain clock and data lines
`timescale 1ns/10ps
`default_nettype none
module iscp_ctrl_model
(
  // clock
  input wire logic clk,
  // wired data level
  input wire logic sda,
  // pull-downs: high pulls the line low, low leaves it to the pull-up
  output logic scl_low,
  output logic sda_low
);
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one bus clock of 16 cycles (160 ns); data moves only while clock is low
  task automatic bit_io(input logic b, output logic got);
    sda_low <= ~b;
    tick(4);
    scl_low <= 1'b0;
    tick(4);
    @(negedge clk) got = sda;
    tick(4);
    scl_low <= 1'b1;
    tick(4);
  endtask

  // also serves as repeated start from clock low
  task automatic start_cond();
    sda_low <= 1'b0;
    tick(4);
    scl_low <= 1'b0;
    tick(4);
    sda_low <= 1'b1;
    tick(4);
    scl_low <= 1'b1;
    tick(4);
  endtask

  task automatic stop_cond();
    sda_low <= 1'b1;
    tick(4);
    scl_low <= 1'b0;
    tick(4);
    sda_low <= 1'b0;
    tick(4);
  endtask

  task automatic send_byte(input logic [7:0] d, output logic nack);
    logic g;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], g);
    bit_io(1'b1, nack);
  endtask

  task automatic recv_byte(input logic nack, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(nack, g);
  endtask
endmodule
`default_nettype wire

// [verification/iscp_top_bench.sv]
// testbench for the serial configuration port
`timescale 1ns/10ps
`default_nettype none
module iscp_top_bench;
  import iscp_pkg::*;
  logic clk, rst, sel_a, sel_b, low_power, scl_low, sda_low;
  logic scl_in, sda_in, scl_out, scl_oe, sda_out, sda_oe;
  logic wake_pulse, tx_data_valid, frac;
  logic [23:0] word;
  logic [1:0] div, dly;
  logic [7:0] tx_data;
  int n_fail = 0;
  int checks_done = 0;
  int n_wake = 0;
  int n_tx = 0;
  int cyc = 0;

  // wired-and bus with pull-ups; preset mode owns the clock pin
  assign scl_in = scl_oe ? scl_out : ~scl_low;
  assign sda_in = ~((sda_oe & ~sda_out) | sda_low);

  iscp_top iscp_top_i (
    .clk(clk), .rst(rst),
    .config_select_a(sel_a), .config_select_b(sel_b),
    .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .low_power(low_power), .wake_pulse(wake_pulse),
    .carrier_word_a(word), .osc_divider_select(div),
    .fractional_synth_enable(frac), .clock_output_delay(dly),
    .tx_data_valid(tx_data_valid), .tx_data(tx_data)
  );

  iscp_ctrl_model iscp_ctrl_model_i (
    .clk(clk), .sda(sda_in), .scl_low(scl_low), .sda_low(sda_low)
  );

  initial clk = 1'b0;
  always #5 clk = ~clk;

  // strobe counters and hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (wake_pulse === 1'b1)
      n_wake <= n_wake + 1;
    if (tx_data_valid === 1'b1)
      n_tx <= n_tx + 1;
    if (cyc == 40000)
    begin
      n_fail++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [23:0] exp,
                     input logic [23:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] q[$]);
    logic nk;
    iscp_ctrl_model_i.start_cond();
    iscp_ctrl_model_i.send_byte(8'hd2, nk);
    chk("write addr ack", 24'h0, {23'h0, nk});
    iscp_ctrl_model_i.send_byte(idx, nk);
    chk("index ack", 24'h0, {23'h0, nk});
    foreach (q[i])
    begin
      iscp_ctrl_model_i.send_byte(q[i], nk);
      chk("data ack", 24'h0, {23'h0, nk});
    end
    iscp_ctrl_model_i.stop_cond();
  endtask

  task automatic rd(input logic [7:0] idx, input int n,
                    output logic [7:0] q[$]);
    logic nk;
    logic [7:0] b;
    q = {};
    iscp_ctrl_model_i.start_cond();
    iscp_ctrl_model_i.send_byte(8'hd2, nk);
    iscp_ctrl_model_i.send_byte(idx, nk);
    iscp_ctrl_model_i.start_cond();
    iscp_ctrl_model_i.send_byte(8'hd3, nk);
    chk("read addr ack", 24'h0, {23'h0, nk});
    for (int i = 0; i < n; i++)
    begin
      iscp_ctrl_model_i.recv_byte(i == n - 1, b);
      q.push_back(b);
    end
    iscp_ctrl_model_i.stop_cond();
  endtask

  initial
  begin
    logic [7:0] q[$];
    logic [7:0] b;
    logic nk;
    int w0;
    int t0;
    time ta;
    rst = 1'b1;
    sel_a = 1'b0;
    sel_b = 1'b0;
    low_power = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk("delay in programming", 24'h0, dly);
    chk("clock pin drive", 24'h0, scl_oe);
    chk("idle lines", 24'h3, {scl_in, sda_in});
    $display("test reset done");
    // every divider code, fraction bit both ways
    for (int i = 0; i < 4; i++)
    begin
      b = {i[0] == 0, 5'h0, i[1:0]};
      wr(8'h08, {b});
      chk("divider", i[1:0], div);
      chk("fraction", i[0] == 0, frac);
    end
    $display("test divider done");
    wr(8'h0b, {8'h12, 8'h34, 8'h57});
    chk("carrier word", 24'h123457, word);
    rd(8'h0b, 3, q);
    chk("read word", 24'h123457, {q[0], q[1], q[2]});
    rd(8'h01, 1, q);
    chk("delay reset", 24'h80, q[0]);
    chk("idle after stop", 24'h3, {scl_in, sda_in});
    $display("test burst done");
    t0 = n_tx;
    wr(8'h13, {8'h5a, 8'ha5, 8'h3c});
    chk("tx strobes", 24'h3, n_tx - t0);
    chk("tx byte", 24'h3c, tx_data);
    rd(8'h14, 1, q);
    chk("next index untouched", 24'h0, q[0]);
    $display("test tx data done");
    iscp_ctrl_model_i.start_cond();
    iscp_ctrl_model_i.send_byte(8'ha0, nk);
    chk("foreign ack", 24'h1, {23'h0, nk});
    iscp_ctrl_model_i.send_byte(8'h0b, nk);
    chk("foreign data ack", 24'h1, {23'h0, nk});
    iscp_ctrl_model_i.stop_cond();
    $display("test foreign done");
    low_power <= 1'b1;
    w0 = n_wake;
    iscp_ctrl_model_i.start_cond();
    iscp_ctrl_model_i.send_byte(8'hd2, nk);
    chk("standby addr ack", 24'h0, {23'h0, nk});
    chk("wake strobe", 24'h1, n_wake - w0);
    iscp_ctrl_model_i.send_byte(8'h0b, nk);
    chk("standby index ack", 24'h1, {23'h0, nk});
    iscp_ctrl_model_i.send_byte(8'h99, nk);
    iscp_ctrl_model_i.stop_cond();
    chk("standby word", 24'h123457, word);
    low_power <= 1'b0;
    wr(8'h0b, {8'h99});
    chk("retried word", 24'h993457, word);
    $display("test standby done");
    sel_a <= 1'b1;
    repeat (4) @(posedge clk);
    chk("preset pin drive", 24'h1, scl_oe);
    chk("preset delay", 24'h2, dly);
    @(posedge scl_out);
    ta = $time;
    @(posedge scl_out);
    chk("clock out period", 2 * ISCP_BUFFERED_CLOCK_OUTPUT_HALF * 10, $time - ta);
    $display("test preset done");
    conclude();
  end
endmodule
`default_nettype wire
